// ===== hw/iec_map.svh
// Register offsets, field positions, reset values and fixed counts of the controller.
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH

`define IEC_NODES 16
`define IEC_CHANS 8
`define IEC_FAST 4
`define IEC_PERIPH 8
`define IEC_TRAP_BASE 7'h10

`define IEC_OFS_NODE 8'h00
`define IEC_WIN_NODE 8'h40
`define IEC_OFS_CCTL 8'h40
`define IEC_OFS_SRC 8'h60
`define IEC_OFS_DST 8'h80
`define IEC_WIN_CHAN 8'h20
`define IEC_OFS_EDGE 8'ha0
`define IEC_OFS_STAT 8'ha4

`define IEC_LVL_LSB 0
`define IEC_IE_BIT 4
`define IEC_IR_BIT 5
`define IEC_XM_BIT 6
`define IEC_CH_LSB 8

`define IEC_CNT_LSB 0
`define IEC_CONT_BIT 8
`define IEC_BYTE_BIT 9
`define IEC_INCS_BIT 10
`define IEC_INCD_BIT 11

`define IEC_EDGE_RISE 2'h1
`define IEC_EDGE_FALL 2'h2

`define IEC_LVL_RST 4'h0
`define IEC_CH_RST 3'h0
`define IEC_CNT_RST 8'h00
`define IEC_PTR_RST 16'h0000
`define IEC_EDGE_RST 8'h00
`define IEC_STEP_BYTE 16'h0001
`define IEC_STEP_WORD 16'h0002

`endif

// ===== hw/iec_pkg.sv
// Types shared by the controller modules.
package iec_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_IRQ} iec_state_e;
    typedef logic [3:0] iec_level_t;
    typedef logic [15:0] iec_ptr_t;
endpackage : iec_pkg

// ===== hw/iec_edge.sv
// Synchroniser and edge detector for the fast external request pins.
`timescale 1ns/10ps
`include "iec_map.svh"

module iec_edge
    import iec_pkg::*;
(
    input logic clk,
    input logic srst,
    input logic [`IEC_FAST-1:0] pin,
    input logic [2*`IEC_FAST-1:0] mode,
    output logic [`IEC_FAST-1:0] pulse
);
    logic [`IEC_FAST-1:0] s1;
    logic [`IEC_FAST-1:0] s2;
    logic [`IEC_FAST-1:0] s3;

    // The first stage only feeds the second; all edge logic looks at s2 and s3.
    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin edge selection
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < `IEC_FAST; gi++) begin : g_pin
        wire rise_en = mode[2*gi];
        wire fall_en = mode[2*gi+1];
        assign pulse[gi] = (rise_en && s2[gi] && !s3[gi]) ||
                           (fall_en && !s2[gi] && s3[gi]); // see (RULE_11)

        a_edge_rise: assert property ( // see (RULE_11)
            @(posedge clk) disable iff (srst)
            rise_en && !s3[gi] && s2[gi] |-> pulse[gi] ##1 !pulse[gi] || s2[gi] != s3[gi])
            else $error("Selected rising edge gave no single pulse.");
        a_edge_quiet: assert property ( // see (RULE_11)
            @(posedge clk) disable iff (srst)
            mode[2*gi+:2] == 2'h0 |-> !pulse[gi])
            else $error("Disabled pin produced a request.");
    end
endmodule : iec_edge

// ===== hw/iec_ctrl.sv
// Interrupt controller with vectored nodes and an eight-channel single-transfer engine.
`timescale 1ns/10ps
`include "iec_map.svh"

// What this block does
// (RULE_01) Each node is set to vectored interrupt or single transfer service.
// (RULE_02) A transfer takes one stolen CPU cycle, no program branch.
// (RULE_03) A transfer moves a byte or word, optionally bumping source and destination.
// (RULE_04) Each transfer decrements the channel count unless in continuous mode.
// (RULE_05) Count reaching zero leaves a vectored interrupt at the node's vector.
// (RULE_06) Eight independent transfer channels exist.
// (RULE_07) Every node has a control register with request, enable and level.
// (RULE_08) The level field offers sixteen levels per node.
// (RULE_09) An accepted service is only preempted by a strictly higher level.
// (RULE_10) Every node vectors to its own distinct location.
// (RULE_11) Fast pins detect rising, falling or both edges.
// (RULE_12) Trap instructions carry a number that selects the vector.
// (RULE_13) Software can set a node's request bit to raise a request.
// (RULE_14) Node vector is four times its trap number, base trap 10H.
// (RULE_15) Response comes within about eight clocks.
// (RULE_16) Highest level wins; equal levels go to the lower node number.
// (RULE_17) Servicing a node clears its request flag in hardware.
module iec_ctrl
    import iec_pkg::*;
(
    input logic CLK,
    input logic SRST,
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic [2:0] HSIZE,
    input logic [31:0] HWDATA,
    input logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input logic [`IEC_FAST-1:0] FAST_PIN,
    input logic [`IEC_PERIPH-1:0] PERIPH_REQ,
    input logic [3:0] CPU_PRIO,
    output logic IRQ_REQ,
    output logic [8:0] IRQ_VECTOR,
    output logic [3:0] IRQ_LEVEL,
    input logic IRQ_ACK,
    output logic XFER_REQ,
    output logic [15:0] XFER_SRC,
    output logic [15:0] XFER_DST,
    output logic XFER_BYTE,
    input logic XFER_ACK,
    input logic TRAP_VALID,
    input logic [6:0] TRAP_NUM,
    output logic TRAP_TAKEN,
    output logic [8:0] TRAP_VEC
);
    localparam int NN = `IEC_NODES;
    localparam int NC = `IEC_CHANS;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iec_level_t node_lvl [NN];
    logic [NN-1:0] node_ie;
    logic [NN-1:0] node_req;
    logic [NN-1:0] node_xm;
    logic [2:0] node_ch [NN];
    logic [7:0] ch_cnt [NC];
    logic [NC-1:0] ch_cont;
    logic [NC-1:0] ch_byte;
    logic [NC-1:0] ch_incs;
    logic [NC-1:0] ch_incd;
    iec_ptr_t ch_src [NC];
    iec_ptr_t ch_dst [NC];
    logic [7:0] edge_cfg;
    iec_state_e state;
    logic [3:0] cur_node;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rd_data;
    logic [`IEC_FAST-1:0] fast_pulse;
    logic [NN-1:0] node_evt;
    logic [NN-1:0] sw_set;
    logic [NN-1:0] sw_clr;
    logic [NN-1:0] svc_clr;
    logic [NN-1:0] elig;
    logic [NN-1:0] use_x;
    logic [4:0] pk;

    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] size);
        return (a >= base) && (a < base + size);
    endfunction : in_win

    function automatic logic [4:0] pick(input logic [NN-1:0] cand, input iec_level_t lv [NN]);
        logic found;
        logic [3:0] idx;
        iec_level_t best;
        found = 1'b0;
        idx = 4'h0;
        best = 4'h0;
        for (int i = 0; i < NN; i++) begin
            if (cand[i] && (!found || lv[i] > best)) begin // see (RULE_16)
                found = 1'b1;
                idx = 4'(i);
                best = lv[i];
            end
        end
        return {found, idx};
    endfunction : pick

    wire pk_found = pk[4];
    wire [3:0] pk_idx = pk[3:0];
    wire [2:0] cur_ch = node_ch[cur_node];
    wire [7:0] cur_cnt = ch_cnt[cur_ch];
    wire [15:0] cur_src = ch_src[cur_ch];
    wire [15:0] cur_dst = ch_dst[cur_ch];
    wire [15:0] step = ch_byte[cur_ch] ? `IEC_STEP_BYTE : `IEC_STEP_WORD;
    wire xfer_fire = XFER_REQ && XFER_ACK;
    wire irq_fire = IRQ_REQ && IRQ_ACK;
    wire last_xfer = !ch_cont[cur_ch] && cur_cnt == 8'h01;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Zero wait states; only the low address byte decodes, so the map repeats.
    wire ap_take = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ap_wr <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_wr <= ap_take && HWRITE;
            ap_addr <= HADDR[7:0];
        end
    end

    wire wr_node = ap_wr && in_win(ap_addr, `IEC_OFS_NODE, `IEC_WIN_NODE);
    wire wr_cctl = ap_wr && in_win(ap_addr, `IEC_OFS_CCTL, `IEC_WIN_CHAN);
    wire wr_src = ap_wr && in_win(ap_addr, `IEC_OFS_SRC, `IEC_WIN_CHAN);
    wire wr_dst = ap_wr && in_win(ap_addr, `IEC_OFS_DST, `IEC_WIN_CHAN);
    wire wr_edge = ap_wr && ap_addr == `IEC_OFS_EDGE;
    wire [3:0] wn = ap_addr[5:2];
    wire [2:0] wc = ap_addr[4:2];
    wire [3:0] rn = HADDR[5:2];
    wire [2:0] rc = HADDR[4:2];
    wire keep_wr = !xfer_fire || wc != cur_ch;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_win(HADDR[7:0], `IEC_OFS_NODE, `IEC_WIN_NODE)) begin
            rd_data[`IEC_LVL_LSB +: 4] = node_lvl[rn];
            rd_data[`IEC_IE_BIT] = node_ie[rn];
            rd_data[`IEC_IR_BIT] = node_req[rn];
            rd_data[`IEC_XM_BIT] = node_xm[rn];
            rd_data[`IEC_CH_LSB +: 3] = node_ch[rn];
        end else if (in_win(HADDR[7:0], `IEC_OFS_CCTL, `IEC_WIN_CHAN)) begin
            rd_data[`IEC_CNT_LSB +: 8] = ch_cnt[rc];
            rd_data[`IEC_CONT_BIT] = ch_cont[rc];
            rd_data[`IEC_BYTE_BIT] = ch_byte[rc];
            rd_data[`IEC_INCS_BIT] = ch_incs[rc];
            rd_data[`IEC_INCD_BIT] = ch_incd[rc];
        end else if (in_win(HADDR[7:0], `IEC_OFS_SRC, `IEC_WIN_CHAN)) begin
            rd_data[15:0] = ch_src[rc];
        end else if (in_win(HADDR[7:0], `IEC_OFS_DST, `IEC_WIN_CHAN)) begin
            rd_data[15:0] = ch_dst[rc];
        end else if (HADDR[7:0] == `IEC_OFS_EDGE) begin
            rd_data[7:0] = edge_cfg;
        end else if (HADDR[7:0] == `IEC_OFS_STAT) begin
            rd_data = {11'h000, state != ST_IDLE, cur_node, node_req};
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            HRDATA <= 32'h0000_0000;
        end else if (ap_take && !HWRITE) begin
            HRDATA <= rd_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            edge_cfg <= `IEC_EDGE_RST;
        end else if (wr_edge) begin
            edge_cfg <= HWDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Request sources
    // ----------------------------------------------------------------
    iec_edge u_edge (
        .clk(CLK),
        .srst(SRST),
        .pin(FAST_PIN),
        .mode(edge_cfg),
        .pulse(fast_pulse)
    ); // see (RULE_11)

    // The top four nodes have no hardware source and serve software requests.
    assign node_evt = {4'h0, PERIPH_REQ, fast_pulse};

    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_node) begin
            sw_set[wn] = HWDATA[`IEC_IR_BIT]; // see (RULE_13)
            sw_clr[wn] = !HWDATA[`IEC_IR_BIT];
        end
    end

    always_comb begin
        svc_clr = '0;
        if (irq_fire || (xfer_fire && !last_xfer)) begin
            svc_clr[cur_node] = 1'b1; // see (RULE_17) (RULE_05)
        end
    end

    // ----------------------------------------------------------------
    // Node control registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            node_ie <= '0;
            node_req <= '0;
            node_xm <= '0;
            for (int i = 0; i < NN; i++) begin
                node_lvl[i] <= `IEC_LVL_RST;
                node_ch[i] <= `IEC_CH_RST;
            end
        end else begin
            // A new event beats a clear in the same cycle.
            for (int i = 0; i < NN; i++) begin
                if (node_evt[i] || sw_set[i]) begin
                    node_req[i] <= 1'b1;
                end else if (sw_clr[i] || svc_clr[i]) begin
                    node_req[i] <= 1'b0; // see (RULE_17)
                end
            end
            if (wr_node) begin
                node_lvl[wn] <= HWDATA[`IEC_LVL_LSB +: 4]; // see (RULE_07) (RULE_08)
                node_ie[wn] <= HWDATA[`IEC_IE_BIT];
                node_xm[wn] <= HWDATA[`IEC_XM_BIT]; // see (RULE_01)
                node_ch[wn] <= HWDATA[`IEC_CH_LSB +: 3];
            end
        end
    end

    // ----------------------------------------------------------------
    // Transfer channels
    // ----------------------------------------------------------------
    // The engine update wins over a bus write to the same channel.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ch_cont <= '0;
            ch_byte <= '0;
            ch_incs <= '0;
            ch_incd <= '0;
            for (int c = 0; c < NC; c++) begin // see (RULE_06)
                ch_cnt[c] <= `IEC_CNT_RST;
                ch_src[c] <= `IEC_PTR_RST;
                ch_dst[c] <= `IEC_PTR_RST;
            end
        end else begin
            if (wr_cctl && keep_wr) begin
                ch_cnt[wc] <= HWDATA[`IEC_CNT_LSB +: 8];
                ch_cont[wc] <= HWDATA[`IEC_CONT_BIT];
                ch_byte[wc] <= HWDATA[`IEC_BYTE_BIT];
                ch_incs[wc] <= HWDATA[`IEC_INCS_BIT];
                ch_incd[wc] <= HWDATA[`IEC_INCD_BIT];
            end
            if (wr_src && keep_wr) begin
                ch_src[wc] <= HWDATA[15:0];
            end
            if (wr_dst && keep_wr) begin
                ch_dst[wc] <= HWDATA[15:0];
            end
            if (xfer_fire) begin
                if (!ch_cont[cur_ch]) begin
                    ch_cnt[cur_ch] <= cur_cnt - 8'h01; // see (RULE_04)
                end
                if (ch_incs[cur_ch]) begin
                    ch_src[cur_ch] <= cur_src + step; // see (RULE_03)
                end
                if (ch_incd[cur_ch]) begin
                    ch_dst[cur_ch] <= cur_dst + step; // see (RULE_03)
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Arbitration and service
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NN; i++) begin
            elig[i] = node_req[i] && node_ie[i] && (node_lvl[i] > CPU_PRIO); // see (RULE_09)
            use_x[i] = node_xm[i] && (ch_cnt[node_ch[i]] != 8'h00 || ch_cont[node_ch[i]]);
        end
    end

    assign pk = pick(elig, node_lvl); // see (RULE_16)

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= ST_IDLE;
            cur_node <= 4'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (pk_found) begin
                        cur_node <= pk_idx;
                        state <= use_x[pk_idx] ? ST_XFER : ST_IRQ; // see (RULE_01) (RULE_05)
                    end
                end
                ST_XFER: begin
                    if (XFER_ACK) begin
                        state <= ST_IDLE; // see (RULE_02)
                    end
                end
                ST_IRQ: begin
                    // Withdraw when the node lost its claim or a better one won.
                    if (IRQ_ACK) begin
                        state <= ST_IDLE;
                    end else if (!elig[cur_node] || pk_idx != cur_node) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign IRQ_REQ = state == ST_IRQ;
    assign XFER_REQ = state == ST_XFER; // see (RULE_02)

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ_LEVEL <= 4'h0;
            IRQ_VECTOR <= 9'h000;
            XFER_SRC <= `IEC_PTR_RST;
            XFER_DST <= `IEC_PTR_RST;
            XFER_BYTE <= 1'b0;
        end else if (state == ST_IDLE && pk_found) begin
            IRQ_LEVEL <= node_lvl[pk_idx];
            IRQ_VECTOR <= {`IEC_TRAP_BASE + 7'(pk_idx), 2'b00}; // see (RULE_10) (RULE_14)
            XFER_SRC <= ch_src[node_ch[pk_idx]];
            XFER_DST <= ch_dst[node_ch[pk_idx]];
            XFER_BYTE <= ch_byte[node_ch[pk_idx]];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            TRAP_TAKEN <= 1'b0;
            TRAP_VEC <= 9'h000;
        end else begin
            TRAP_TAKEN <= TRAP_VALID;
            if (TRAP_VALID) begin
                TRAP_VEC <= {TRAP_NUM, 2'b00}; // see (RULE_12)
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_xfer_one_cycle: assert property ( // see (RULE_02)
        xfer_fire |=> !XFER_REQ && !IRQ_REQ)
        else $error("Transfer held the CPU beyond one cycle.");
    a_cnt_decrement: assert property ( // see (RULE_04)
        xfer_fire |=> ch_cnt[$past(cur_ch)] ==
            ($past(ch_cont[cur_ch]) ? $past(cur_cnt) : $past(cur_cnt) - 8'h01))
        else $error("Transfer count moved wrongly.");
    a_src_step: assert property ( // see (RULE_03)
        xfer_fire && ch_incs[cur_ch] |=> ch_src[$past(cur_ch)] == $past(cur_src) + $past(step))
        else $error("Source pointer not advanced by one unit.");
    a_zero_keeps_irq: assert property ( // see (RULE_05)
        xfer_fire && last_xfer |=> node_req[$past(cur_node)] && !use_x[$past(cur_node)])
        else $error("Final transfer did not leave a vectored request.");
    a_irq_level_above: assert property ( // see (RULE_09)
        IRQ_REQ |-> IRQ_LEVEL > $past(CPU_PRIO))
        else $error("Interrupt offered at or below the running level.");
    a_vector_map: assert property ( // see (RULE_14)
        IRQ_REQ |-> IRQ_VECTOR == {`IEC_TRAP_BASE + 7'(cur_node), 2'b00})
        else $error("Vector does not match the node trap number.");
    a_resp_time: assert property ( // see (RULE_15)
        state == ST_IDLE && pk_found && !use_x[pk_idx] |-> ##[1:8] IRQ_REQ)
        else $error("No interrupt offered within eight clocks.");
    a_flag_cleared: assert property ( // see (RULE_17)
        irq_fire && !node_evt[cur_node] && !sw_set[cur_node] |=> !node_req[$past(cur_node)])
        else $error("Serviced request flag was not cleared.");
    a_trap_vector: assert property ( // see (RULE_12)
        TRAP_VALID |=> TRAP_TAKEN && TRAP_VEC == {$past(TRAP_NUM), 2'b00})
        else $error("Trap number did not select its vector.");
endmodule : iec_ctrl

// ===== testbench/iec_cpu_model.sv
// CPU-side model that takes vectored interrupts and gives up cycles for transfers.
`timescale 1ns/10ps

// ----------------------------------------
// CPU core model
// ----------------------------------------
module iec_cpu_model (
    input logic clk,
    input logic srst,
    input logic [3:0] dly,
    input logic irq_req,
    input logic [8:0] irq_vector,
    input logic [3:0] irq_level,
    output logic irq_ack,
    input logic xfer_req,
    input logic [15:0] xfer_src,
    input logic [15:0] xfer_dst,
    input logic xfer_byte,
    output logic xfer_ack
);
    logic [8:0] vq[$];
    logic [3:0] lq[$];
    logic [32:0] xq[$];
    int clash;
    logic [3:0] icnt;
    logic [3:0] xcnt;

    // A busy core answers late; the delay input lets the bench play both kinds of core.
    always @(posedge clk) begin
        if (srst) begin
            irq_ack <= 1'b0;
            xfer_ack <= 1'b0;
            icnt <= 4'h0;
            xcnt <= 4'h0;
            clash <= 0;
        end else begin
            if (irq_ack && irq_req) begin
                vq.push_back(irq_vector);
                lq.push_back(irq_level);
            end
            if (xfer_ack && xfer_req) begin
                xq.push_back({xfer_byte, xfer_src, xfer_dst});
            end
            if (irq_req && xfer_req) begin
                clash <= clash + 1;
            end
            if (irq_ack || !irq_req) begin
                irq_ack <= 1'b0;
                icnt <= 4'h0;
            end else if (icnt == dly) begin
                irq_ack <= 1'b1;
            end else begin
                icnt <= icnt + 4'h1;
            end
            if (xfer_ack || !xfer_req) begin
                xfer_ack <= 1'b0;
                xcnt <= 4'h0;
            end else if (xcnt == dly) begin
                xfer_ack <= 1'b1;
            end else begin
                xcnt <= xcnt + 4'h1;
            end
        end
    end
endmodule : iec_cpu_model

// ===== testbench/testbench.sv
// Self-checking bench for the interrupt and transfer controller.
`timescale 1ns/10ps

// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic HSEL, HWRITE, HREADYOUT, HRESP, IRQ_REQ, IRQ_ACK, XFER_REQ, XFER_BYTE, XFER_ACK;
    logic TRAP_VALID, TRAP_TAKEN;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [3:0] FAST_PIN, CPU_PRIO, IRQ_LEVEL, dly;
    logic [7:0] PERIPH_REQ;
    logic [8:0] IRQ_VECTOR, TRAP_VEC;
    logic [15:0] XFER_SRC, XFER_DST;
    logic [6:0] TRAP_NUM;
    int fails = 0;
    int n_checks = 0;

    iec_ctrl uut (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FAST_PIN(FAST_PIN),
        .PERIPH_REQ(PERIPH_REQ), .CPU_PRIO(CPU_PRIO), .IRQ_REQ(IRQ_REQ),
        .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_ACK(IRQ_ACK),
        .XFER_REQ(XFER_REQ), .XFER_SRC(XFER_SRC), .XFER_DST(XFER_DST),
        .XFER_BYTE(XFER_BYTE), .XFER_ACK(XFER_ACK), .TRAP_VALID(TRAP_VALID),
        .TRAP_NUM(TRAP_NUM), .TRAP_TAKEN(TRAP_TAKEN), .TRAP_VEC(TRAP_VEC));

    iec_cpu_model m (.clk(CLK), .srst(SRST), .dly(dly), .irq_req(IRQ_REQ),
        .irq_vector(IRQ_VECTOR), .irq_level(IRQ_LEVEL), .irq_ack(IRQ_ACK),
        .xfer_req(XFER_REQ), .xfer_src(XFER_SRC), .xfer_dst(XFER_DST),
        .xfer_byte(XFER_BYTE), .xfer_ack(XFER_ACK));

    initial begin
        forever #2.5 CLK = ~CLK;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick

    // Zero wait states are not assumed: each phase waits for ready.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h000000, a};
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
        #1;
    endtask : bus

    // The idle cycle after a write only spaces accesses; a following read would see the new value without it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        tick(1);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] k,
        input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r & k);
    endtask : rd

    task automatic wait_for(input int nv, input int nx, input int lim);
        for (int i = 0; i < lim && (m.vq.size() < nv || m.xq.size() < nx); i++) tick(1);
    endtask : wait_for

    task automatic chk_v(input int n, input logic [3:0] l);
        logic [8:0] v = 9'h1ff;
        logic [3:0] g = 4'h0;
        if (m.vq.size() != 0) begin
            v = m.vq.pop_front();
            g = m.lq.pop_front();
        end
        chk("irq vector", 32'((16 + n) * 4), {23'h0, v});
        chk("irq level", {28'h0, l}, {28'h0, g});
    endtask : chk_v

    task automatic chk_x(input logic b, input logic [15:0] s, input logic [15:0] d);
        logic [32:0] x = 33'h0;
        if (m.xq.size() != 0) x = m.xq.pop_front();
        chk("xfer byte", {31'h0, b}, {31'h0, x[32]});
        chk("xfer src", {16'h0, s}, {16'h0, x[31:16]});
        chk("xfer dst", {16'h0, d}, {16'h0, x[15:0]});
    endtask : chk_x

    task automatic t_regs;
        rd("status", 8'ha4, 32'h001fffff, 32'h0);
        chk("hresp", 32'h0, {31'h0, HRESP});
        wr(8'h30, 32'h71f);
        rd("node ctrl", 8'h30, 32'hffffffff, 32'h71f);
        wr(8'h30, 32'h0);
        wr(8'hfc, 32'hffffffff);
        rd("unmapped", 8'hfc, 32'hffffffff, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_soft;
        wr(8'h30, 32'h35);
        wait_for(1, 0, 8);
        chk_v(12, 4'h5);
        rd("flags", 8'ha4, 32'hffff, 32'h0);
        $display("test soft done");
    endtask : t_soft

    task automatic t_prio;
        CPU_PRIO <= 4'h9;
        dly <= 4'h2;
        wr(8'h34, 32'h33);
        wr(8'h38, 32'h39);
        wr(8'h3c, 32'h39);
        tick(20);
        chk("refused", 32'h0, m.vq.size());
        wr(8'h30, 32'h3a);
        wait_for(1, 0, 20);
        chk_v(12, 4'ha);
        CPU_PRIO <= 4'h0;
        wait_for(3, 0, 60);
        chk_v(14, 4'h9);
        chk_v(15, 4'h9);
        chk_v(13, 4'h3);
        $display("test prio done");
    endtask : t_prio

    task automatic t_periph;
        dly <= 4'h0;
        wr(8'h10, 32'h12);
        wr(8'h2c, 32'h17);
        PERIPH_REQ <= 8'h81;
        tick(1);
        PERIPH_REQ <= 8'h00;
        wait_for(2, 0, 30);
        chk_v(11, 4'h7);
        chk_v(4, 4'h2);
        $display("test periph done");
    endtask : t_periph

    task automatic t_fast;
        wr(8'ha0, 32'h39);
        rd("edge cfg", 8'ha0, 32'hff, 32'h39);
        for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'h11);
        FAST_PIN <= 4'hf;
        tick(40);
        chk_v(0, 4'h1);
        chk_v(2, 4'h1);
        chk("rise extra", 32'h0, m.vq.size());
        FAST_PIN <= 4'h0;
        tick(40);
        chk_v(1, 4'h1);
        chk_v(2, 4'h1);
        chk("fall extra", 32'h0, m.vq.size());
        $display("test fast done");
    endtask : t_fast

    task automatic t_xfer;
        wr(8'h4c, 32'hc02);
        wr(8'h6c, 32'h1000);
        wr(8'h8c, 32'h2000);
        wr(8'h34, 32'h374);
        wait_for(0, 1, 20);
        chk_x(1'b0, 16'h1000, 16'h2000);
        rd("count", 8'h4c, 32'hff, 32'h1);
        rd("flags", 8'ha4, 32'hffff, 32'h0);
        wr(8'h34, 32'h374);
        wait_for(1, 1, 30);
        chk_x(1'b0, 16'h1002, 16'h2002);
        chk_v(13, 4'h4);
        rd("count", 8'h4c, 32'hff, 32'h0);
        wr(8'h5c, 32'h705);
        wr(8'h7c, 32'h3000);
        wr(8'h9c, 32'h4000);
        wr(8'h3c, 32'h771);
        tick(20);
        chk_x(1'b1, 16'h3000, 16'h4000);
        rd("cont ctrl", 8'h5c, 32'hfff, 32'h705);
        rd("src ptr", 8'h7c, 32'hffff, 32'h3001);
        rd("dst ptr", 8'h9c, 32'hffff, 32'h4000);
        chk("vectored", 32'h0, m.vq.size());
        chk("clash", 32'h0, m.clash);
        $display("test xfer done");
    endtask : t_xfer

    task automatic trap(input logic [6:0] n);
        TRAP_VALID <= 1'b1;
        TRAP_NUM <= n;
        tick(1);
        TRAP_VALID <= 1'b0;
        chk("trap taken", 32'h1, {31'h0, TRAP_TAKEN});
        chk("trap vec", {23'h0, n, 2'b00}, {23'h0, TRAP_VEC});
        tick(1);
        chk("trap end", 32'h0, {31'h0, TRAP_TAKEN});
        $display("test trap done");
    endtask : trap

    initial begin
        HSEL = 1'b0;
        HWRITE = 1'b0;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        HTRANS = 2'h0;
        HSIZE = 3'h2;
        FAST_PIN = 4'h0;
        CPU_PRIO = 4'h0;
        PERIPH_REQ = 8'h00;
        TRAP_VALID = 1'b0;
        TRAP_NUM = 7'h00;
        dly = 4'h0;
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        tick(1);
        t_regs;
        t_soft;
        t_prio;
        t_periph;
        t_fast;
        t_xfer;
        trap(7'h10);
        trap(7'h7f);
        print_verdict;
    end

    // The run needs a few hundred cycles; twenty thousand marks a hang.
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        print_verdict;
    end
endmodule : testbench
